/* File: src/slfap_bank.sv */
// Address pointer bank 1..11 of the sensor line formatter, plus mode, length
// and step controls that give the pointers their meaning.
// Assumes a plain strobe register port synchronous to i_mclk.
//
// The plain strobed port and the placing of the registers were decided locally.
`include "slfap_cfg.svh"
module slfap_bank
  import slfap_pkg::*;
#(
  parameter int NPTR = `SLFAP_PTR_COUNT
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_vsync,
  input wire logic [3:0] i_sel,
  output logic [31:0] o_rdata,
  output logic o_combine,
  output logic [4:0] o_step,
  output logic [12:0] o_line_len,
  output logic [12:0] o_sel_init,
  output logic [1:0] o_sel_line,
  output logic o_sel_line_valid,
  output logic o_len_error
);
  // Offsets above 15 pointers would run into the control word
  if (NPTR < 1 || NPTR > 14) begin : g_bad_nptr
    $error("NPTR out of range");
  end

  slfap_line_type line_w [NPTR];
  slfap_addr_type init_w [NPTR];
  logic [NPTR-1:0] ptr_wr;
  logic ctrl_cbl_q;
  logic [3:0] ctrl_step_q;
  logic [12:0] len_q;
  slfap_mode_type mode_q;
  logic [4:0] step_q;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic [12:0] sel_init_q;
  logic [1:0] sel_line_q;
  logic sel_valid_q;
  logic combine_q;
  logic len_err_q;
  logic [3:0] sel_idx;

  genvar g;
  generate
    for (g = 0; g < NPTR; g++) begin : g_ptr
      assign ptr_wr[g] = i_wr && (i_addr == 8'(`SLFAP_PTR_BASE + 4 * g)); // RQ6
      slfap_ptr_reg u_ptr (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_wr(ptr_wr[g]),
        .i_wdata(i_wdata),
        .o_line(line_w[g]),
        .o_init(init_w[g])
      );
    end
  endgenerate

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_cbl_q <= 1'h0;
      ctrl_step_q <= 4'h0;
    end else if (i_wr && i_addr == `SLFAP_CTRL_OFS) begin
      ctrl_cbl_q <= i_wdata[`SLFAP_CTRL_CBL];
      ctrl_step_q <= i_wdata[`SLFAP_STEP_MSB:`SLFAP_STEP_LSB];
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      len_q <= 13'h0000;
    end else if (i_wr && i_addr == `SLFAP_LEN_OFS) begin
      len_q <= i_wdata[12:0];
    end
  end

  // Mode and step only change at frame start so a line never mixes settings
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      mode_q <= SLFAP_SPLIT;
      combine_q <= 1'h0;
      step_q <= 5'h01;
    end else if (i_vsync) begin
      mode_q <= ctrl_cbl_q ? SLFAP_COMBINE : SLFAP_SPLIT; // RQ7
      combine_q <= ctrl_cbl_q; // RQ7
      step_q <= {1'h0, ctrl_step_q} + 5'h01; // RQ9
    end
  end

  // Reserved bits come out as zero; unmapped offsets read zero
  always_comb begin
    rdata_d = `SLFAP_RESET_WORD;
    for (int i = 0; i < NPTR; i++) begin
      if (i_addr == 8'(`SLFAP_PTR_BASE + 4 * i)) begin
        rdata_d = {17'h00000, line_w[i], init_w[i]}; // RQ10
      end
    end
    if (i_addr == `SLFAP_CTRL_OFS) begin
      rdata_d = {20'h00000, ctrl_step_q, 7'h00, ctrl_cbl_q};
    end
    if (i_addr == `SLFAP_LEN_OFS) begin
      rdata_d = {19'h00000, len_q};
    end
    if (i_addr == `SLFAP_STAT_OFS) begin
      rdata_d = {26'h0000000, mode_q == SLFAP_COMBINE, step_q};
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= i_rd ? rdata_d : 32'h0000_0000;
    end
  end

  // Pointer index 1..NPTR from the datapath; other values give zero
  assign sel_idx = i_sel - 4'h1;

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      sel_init_q <= 13'h0000;
      sel_line_q <= 2'h0;
      sel_valid_q <= 1'h0;
    end else if (i_sel >= 4'h1 && i_sel <= 4'(NPTR)) begin
      sel_init_q <= init_w[sel_idx]; // RQ4
      sel_line_q <= (mode_q == SLFAP_SPLIT) ? line_w[sel_idx] : 2'h0; // RQ3
      sel_valid_q <= (mode_q == SLFAP_SPLIT); // RQ3
    end else begin
      sel_init_q <= 13'h0000;
      sel_line_q <= 2'h0;
      sel_valid_q <= 1'h0;
    end
  end

  // Flags a length, or a start address of the selected pointer, that software was not allowed to program
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      len_err_q <= 1'h0;
    end else begin
      len_err_q <= (len_q > `SLFAP_LEN_MAX) || // RQ8
        (i_sel >= 4'h1 && i_sel <= 4'(NPTR) && init_w[sel_idx] >= len_q); // RQ5
    end
  end

  assign o_rdata = rdata_q;
  assign o_combine = combine_q;
  assign o_step = step_q;
  assign o_line_len = len_q;
  assign o_sel_init = sel_init_q;
  assign o_sel_line = sel_line_q;
  assign o_sel_line_valid = sel_valid_q;
  assign o_len_error = len_err_q;
endmodule

/* File: src/slfap_cfg.svh */
// Constants for the line formatter address pointer bank: offsets, fields, resets.
// Assumes inclusion by bare name from design and bench files alike.
// Notes on behaviour
// RQ1: Software writes zero into bit 15 and bits 31 to 16 of each pointer.
// RQ2: Bits 14 to 13 select output line one to four for the pointer.
// RQ3: Line selector is used only in split mode, ignored while combining.
// RQ4: Bits 12 to 0 hold the pointer's initial address, 0 to 1FFFh.
// RQ5: Software keeps each initial address below output line length.
// RQ6: Pointers 1 to 11 are separate, identical, independently read and written.
// RQ7: Combine-lines control clear splits lines, set merges lines.
// RQ8: Output line length never above 4480 pixels, software's duty.
// RQ9: Address step is programmed field plus one, latched at vertical sync.
// RQ10: Writable fields reset to zero, reserved bits read as zero.
`ifndef SLFAP_CFG_SVH
`define SLFAP_CFG_SVH
`define SLFAP_PTR_FIRST 1
`define SLFAP_PTR_COUNT 11
`define SLFAP_PTR_BASE 8'h04
`define SLFAP_CTRL_OFS 8'h40
`define SLFAP_LEN_OFS 8'h44
`define SLFAP_STAT_OFS 8'h48
`define SLFAP_INIT_MSB 12
`define SLFAP_LINE_LSB 13
`define SLFAP_LINE_MSB 14
`define SLFAP_CTRL_CBL 0
`define SLFAP_STEP_LSB 8
`define SLFAP_STEP_MSB 11
`define SLFAP_LEN_MAX 13'h1180
`define SLFAP_RESET_WORD 32'h0000_0000
`endif

/* File: src/slfap_pkg.sv */
// Types for the line formatter address pointer bank.
// Assumes nothing beyond the configuration header.
package slfap_pkg;
  typedef logic [12:0] slfap_addr_type;
  typedef logic [1:0] slfap_line_type;
  typedef enum logic [1:0] {
    SLFAP_SPLIT = 2'h1,
    SLFAP_COMBINE = 2'h2
  } slfap_mode_type;
endpackage

/* File: src/slfap_ptr_reg.sv */
// One address pointer register: line selector and initial address.
// Assumes the owner decodes the address and gives a one-cycle write strobe.
`include "slfap_cfg.svh"
module slfap_ptr_reg
  import slfap_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_wr,
  input wire logic [31:0] i_wdata,
  output slfap_line_type o_line,
  output slfap_addr_type o_init
);
  slfap_line_type line_q;
  slfap_addr_type init_q;

  // Reserved bits are never stored, so they cannot read back nonzero
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      line_q <= 2'h0; // RQ10
      init_q <= 13'h0000; // RQ10
    end else if (i_wr) begin
      line_q <= i_wdata[`SLFAP_LINE_MSB:`SLFAP_LINE_LSB]; // RQ2
      init_q <= i_wdata[`SLFAP_INIT_MSB:0]; // RQ4
    end
  end

  assign o_line = line_q;
  assign o_init = init_q;
endmodule

/* File: bench/slfap_bank_assertions.sv */
// Port checker for the pointer bank.
// Assumes it is bound onto slfap_bank.
module slfap_bank_chk (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic [7:0] i_addr,
  input wire logic i_rd,
  input wire logic i_vsync,
  input wire logic [3:0] i_sel,
  input wire logic [31:0] o_rdata,
  input wire logic o_combine,
  input wire logic [4:0] o_step,
  input wire logic [12:0] o_line_len,
  input wire logic [1:0] o_sel_line,
  input wire logic o_sel_line_valid,
  input wire logic o_len_error
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  sequence s_stat_rd;
    $past(i_rd) && $past(i_addr) == 8'h48 && !$past(i_vsync);
  endsequence
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("rdata not idle");
  a_unmapped_zero: assert property ($past(i_rd) && $past(i_addr) == 8'h30 |-> o_rdata == 32'h0)
    else $error("unmapped read");
  a_resv_zero: assert property (o_rdata[31:15] == 17'h0)
    else $error("reserved bits");
  a_status_step: assert property (s_stat_rd |-> o_rdata[5:0] == {o_combine, o_step})
    else $error("status mismatch");
  a_step_hold: assert property (!i_vsync |=> $stable(o_step) && $stable(o_combine))
    else $error("latch moved");
  a_combine_line: assert property (o_combine && $past(o_combine) |-> !o_sel_line_valid)
    else $error("selector used");
  a_sel_valid: assert property ($past(i_sel) inside {[4'h1:4'hB]} && !$past(o_combine)
    |-> o_sel_line_valid) else $error("selector lost");
  a_len_flag: assert property ((o_line_len > 13'h1180) [*2] |-> o_len_error)
    else $error("length flag");
endmodule
bind slfap_bank slfap_bank_chk u_chk (.*);

/* File: bench/test_sensor_line_formatter_addr_ptrs.sv */
// Directed bench for the pointer bank.
// Assumes default pointer count; drives every input itself.
module test_sensor_line_formatter_addr_ptrs;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_mclk = 0, i_resetn = 0, i_wr = 0, i_rd = 0, i_vsync = 0;
  logic [7:0] i_addr = 8'h0;
  logic [31:0] i_wdata = 32'h0, o_rdata;
  logic [3:0] i_sel = 4'h0;
  logic o_combine, o_sel_line_valid, o_len_error;
  logic [4:0] o_step;
  logic [12:0] o_line_len, o_sel_init;
  logic [1:0] o_sel_line;
  int mismatches = 0, checks_done = 0, cyc = 0;
  slfap_bank uut (.*);
  initial forever #5 i_mclk = ~i_mclk;
  // Whole run is about 110 cycles
  always @(posedge i_mclk) if (++cyc == 1000) begin
    mismatches++;
    summarize();
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 chk("rdata", e, o_rdata);
  endtask
  task automatic sel(input logic [3:0] s, input logic [31:0] e);
    @(posedge i_mclk);
    i_sel <= s;
    @(posedge i_mclk);
    #1 chk("sel", e, {o_sel_line_valid, o_sel_line, o_sel_init});
  endtask
  task automatic t_ptrs;
    for (int n = 1; n <= 11; n++) rd(8'(4 * n), 32'h0);
    for (int n = 1; n <= 11; n++) wr(8'(4 * n), {17'h0, 2'(n), 13'h1FFF - 13'(n)});
    for (int n = 1; n <= 11; n++) rd(8'(4 * n), {17'h0, 2'(n), 13'h1FFF - 13'(n)});
    for (int n = 1; n <= 11; n++) sel(4'(n), {1'b1, 2'(n), 13'h1FFF - 13'(n)});
    rd(8'h30, 32'h0);
    $display("pointers done");
  endtask
  task automatic t_mode;
    wr(8'h40, 32'h0000_0F01);
    chk("mode", 32'h1, {o_combine, o_step});
    @(posedge i_mclk);
    i_vsync <= 1'b1;
    @(posedge i_mclk);
    i_vsync <= 1'b0;
    #1 chk("mode", 32'h30, {o_combine, o_step});
    sel(4'h3, {1'b0, 2'h0, 13'h1FFC});
    rd(8'h48, 32'h30);
    wr(8'h44, 32'h1181);
    rd(8'h44, 32'h1181);
    chk("len_err", 32'h1, o_len_error);
    chk("line_len", 32'h1181, o_line_len);
    wr(8'h0C, 32'h0000_0100);
    wr(8'h44, 32'h1180);
    sel(4'h3, {1'b0, 2'h0, 13'h0100});
    chk("len_err", 32'h0, o_len_error);
    $display("mode done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge i_mclk);
    i_resetn <= 1'b1;
    t_ptrs();
    t_mode();
    summarize();
  end
endmodule
